// ===== ccs_pkg.sv
// ccs_pkg: constants, types and register map of the cpu clock source control
// assumes a 250 MHz system clock and a 32-bit classic wishbone register port
package ccs_pkg;
   // -------------------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // -------------------------------------------------------------------------
   localparam logic [7:0] ADR_PROC = 8'h00; // processor_clock_control_reg
   localparam logic [7:0] ADR_MODE = 8'h04; // main_clock_mode_reg
   localparam logic [7:0] ADR_OSC = 8'h08; // oscillator_mode_reg
   localparam logic [7:0] ADR_IOSC = 8'h0C; // internal_osc_mode_reg
   localparam logic [7:0] ADR_MAIN = 8'h10; // main_osc_control_reg
   // -------------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------------
   localparam int B_CPU_SEL = 4; // cpu_source_select
   localparam int B_SUB_ST = 5; // cpu_sub_clock_status (read only)
   localparam int B_SRC_SEL = 2; // main_clock_source_select
   localparam int B_MAIN_ST = 1; // main_clock_status (read only)
   localparam int B_MODE_BIT = 0; // main_clock_mode_bit
   localparam int B_EXT_MAIN = 7; // external_main_input_select
   localparam int B_MAIN_OSC = 6; // main_osc_select
   localparam int B_EXT_SUB = 5; // subsystem_external_input_select
   localparam int B_SUB_SEL = 4; // subsystem_osc_select
   localparam int B_GAIN = 0; // amplifier_gain_select
   localparam int B_LSSTOP = 1; // low_speed_osc_stop
   localparam int B_MAIN_STOP = 7; // main_osc_stop
   // -------------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------------
   localparam logic [7:0] RST_PROC = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_OSC = 8'h00;
   localparam logic [7:0] RST_IOSC = 8'h00;
   localparam logic [7:0] RST_MAIN = 8'h80; // main oscillator stopped
   // -------------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------------
   localparam int CLK_PS = 4000; // 250 MHz period in ps
   localparam int RSTPROC_US = 11; // least reset processing time in us
   localparam int RSTPROC_CYC = (RSTPROC_US * 1000 * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SWITCH_NS = 40; // clock switch settling time
   localparam int SWITCH_CYC = (SWITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   // -------------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------------
   // clock source codes; the low-speed oscillator has no code on purpose
   typedef enum logic [1:0] {
      SRC_IHS = 2'h0,
      SRC_X1 = 2'h1,
      SRC_EXT = 2'h3,
      SRC_SUB = 2'h2
   } ccs_src_e;
   // power-up sequence, gray along wait -> processing -> run
   typedef enum logic [1:0] {
      PU_WAIT = 2'h0,
      PU_PROC = 2'h1,
      PU_RUN = 2'h3
   } ccs_pu_e;
   // oscillator enables driven to the analog side
   typedef struct packed {
      logic ihs_en;   // internal high-speed oscillator
      logic x1_en;    // main crystal amplifier
      logic ext_en;   // external main clock input
      logic amp_hi;   // crystal gain for 10 MHz or more
      logic xt1_en;   // subsystem crystal amplifier
      logic exts_en;  // external subsystem clock input
      logic ls_en;    // internal low-speed oscillator
   } ccs_osc_s;
endpackage

// ===== ccs_clock_ctrl.sv
// ccs_clock_ctrl: register file and selection logic steering cpu and peripheral
// clock sources; assumes glitch-free muxes outside follow the source codes
//
// Functional notes
// - two flags report the active cpu source
// - clearing subsystem select stops subsystem clock
// - stop mode leaves subsystem oscillator running
// - low-speed clock never feeds the cpu
// - low-speed oscillator runs after reset release
// - stop bit halts, clearing restarts low-speed
// - option strap can lock low-speed oscillator on
// - source select zero gives internal peripheral clock
// - source select one: crystal or external peripherals
// - mode bit picks main clock for cpu
// - select and mode bits at documented positions
// - cpu starts on internal high-speed oscillator
// - dual-threshold option adds reset processing interval
// - oscillator mode register bit layout
// - main stop bit seven, zero runs
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module ccs_clock_ctrl #(
   parameter int RSTPROC_CYCLES = ccs_pkg::RSTPROC_CYC, // reset processing time
   parameter int SWITCH_CYCLES = ccs_pkg::SWITCH_CYC    // source switch settling
) (
   input wire logic clk_i,                  // 250 MHz system clock
   input wire logic rst_i,                  // synchronous, active high
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // device pins and straps
   input wire logic ls_stoppable_opt_i,    // option: low-speed may be stopped
   input wire logic dual_threshold_por_option_i, // option: dual-threshold clear
   input wire logic vdd_above_upper_i,     // supply above upper threshold
   input wire logic stop_mode_i,           // stop standby state, same clock
   // clock steering
   output ccs_pkg::ccs_src_e cpu_clk_src_o, // active cpu clock source
   output ccs_pkg::ccs_src_e per_clk_src_o, // peripheral clock source
   output ccs_pkg::ccs_osc_s osc_en_o,     // oscillator enables
   output logic cpu_run_o                  // cpu released from reset state
);
   // -------------------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------------------
   if (RSTPROC_CYCLES < 1 || RSTPROC_CYCLES > 65535) begin : g_chk_rp
      $error("RSTPROC_CYCLES out of range");
   end
   if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255) begin : g_chk_sw
      $error("SWITCH_CYCLES out of range");
   end

   // -------------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------------
   // three asynchronous levels, two flops each; stage one feeds stage two only
   logic [2:0] pin_meta_ff;
   logic [2:0] pin_sync_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_ff <= 3'h0;
         pin_sync_ff <= 3'h0;
      end else begin
         pin_meta_ff <= {vdd_above_upper_i, dual_threshold_por_option_i, ls_stoppable_opt_i};
         pin_sync_ff <= pin_meta_ff;
      end
   end
   wire logic ls_stoppable = pin_sync_ff[0];
   wire logic dual_opt = pin_sync_ff[1];
   wire logic vdd_hi = pin_sync_ff[2];

   // -------------------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------------------
   logic [7:0] proc_ff;  // processor_clock_control_reg
   logic [7:0] mode_ff;  // main_clock_mode_reg
   logic [7:0] osc_ff;   // oscillator_mode_reg
   logic [7:0] iosc_ff;  // internal_osc_mode_reg
   logic [7:0] mainc_ff; // main_osc_control_reg
   logic wb_req;       // fresh request, not yet answered
   logic wr_en;        // write strobe for the low byte lane
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // a write lands at the edge where the master sees ack, not before
   assign wr_en = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

   // writable bit masks; status bits are dropped on write
   localparam logic [7:0] MSK_PROC = 8'h01 << ccs_pkg::B_CPU_SEL;
   localparam logic [7:0] MSK_MODE = (8'h01 << ccs_pkg::B_SRC_SEL) | (8'h01 << ccs_pkg::B_MODE_BIT);
   localparam logic [7:0] MSK_OSC = 8'hF1;
   localparam logic [7:0] MSK_IOSC = 8'h01 << ccs_pkg::B_LSSTOP;
   localparam logic [7:0] MSK_MAIN = 8'h01 << ccs_pkg::B_MAIN_STOP;

   // register writes; reset values leave the cpu on internal oscillator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         proc_ff <= ccs_pkg::RST_PROC;
         mode_ff <= ccs_pkg::RST_MODE;
         osc_ff <= ccs_pkg::RST_OSC;
         iosc_ff <= ccs_pkg::RST_IOSC;
         mainc_ff <= ccs_pkg::RST_MAIN;
      end else if (wr_en) begin
         case (wb_adr_i)
            ccs_pkg::ADR_PROC: begin
               proc_ff <= wb_dat_i[7:0] & MSK_PROC;
            end
            ccs_pkg::ADR_MODE: begin
               mode_ff <= wb_dat_i[7:0] & MSK_MODE;
            end
            ccs_pkg::ADR_OSC: begin
               osc_ff <= wb_dat_i[7:0] & MSK_OSC;
            end
            ccs_pkg::ADR_IOSC: begin
               iosc_ff <= wb_dat_i[7:0] & MSK_IOSC;
            end
            ccs_pkg::ADR_MAIN: begin
               mainc_ff <= wb_dat_i[7:0] & MSK_MAIN;
            end
            default: begin
               // unmapped: write ignored, still acknowledged
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // power-up sequence
   // -------------------------------------------------------------------------
   ccs_pkg::ccs_pu_e pu_ff;
   ccs_pkg::ccs_pu_e nxt_pu;
   logic [15:0] rp_cnt_ff; // reset processing counter
   localparam logic [15:0] RP_LAST = 16'(RSTPROC_CYCLES - 1);
   logic [1:0] fill_ff; // synchroniser holds real strap values

   // straps read zero until the synchroniser has filled; without this
   // a dual-threshold strap would be missed and the interval skipped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fill_ff <= 2'h0;
      end else begin
         fill_ff <= {fill_ff[0], 1'b1};
      end
   end

   // without the dual option the cpu runs right away; with it, it waits
   // for the supply and then the processing interval
   always_comb begin
      nxt_pu = pu_ff;
      case (pu_ff)
         ccs_pkg::PU_WAIT: begin
            if (!fill_ff[1]) begin
               nxt_pu = ccs_pkg::PU_WAIT;
            end else if (!dual_opt) begin
               nxt_pu = ccs_pkg::PU_RUN;
            end else if (vdd_hi) begin
               nxt_pu = ccs_pkg::PU_PROC;
            end
         end
         ccs_pkg::PU_PROC: begin
            if (rp_cnt_ff == RP_LAST) begin
               nxt_pu = ccs_pkg::PU_RUN;
            end
         end
         ccs_pkg::PU_RUN: begin
            nxt_pu = ccs_pkg::PU_RUN;
         end
         default: begin
            nxt_pu = ccs_pkg::PU_WAIT;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pu_ff <= ccs_pkg::PU_WAIT;
      end else begin
         pu_ff <= nxt_pu;
      end
   end

   // interval counter, cleared outside the processing state
   always_ff @(posedge clk_i) begin
      if (rst_i || pu_ff != ccs_pkg::PU_PROC) begin
         rp_cnt_ff <= 16'h0000;
      end else begin
         rp_cnt_ff <= rp_cnt_ff + 16'h0001;
      end
   end

   // cpu release flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_run_o <= 1'b0;
      end else begin
         cpu_run_o <= (nxt_pu == ccs_pkg::PU_RUN);
      end
   end

   // -------------------------------------------------------------------------
   // source selection
   // -------------------------------------------------------------------------
   logic cpu_sel, src_sel, mode_bit, ext_main;
   ccs_pkg::ccs_src_e main_src; // x1 or external main clock
   ccs_pkg::ccs_src_e req_cpu;  // cpu source the registers ask for
   ccs_pkg::ccs_src_e req_per;  // peripheral source the registers ask for
   assign cpu_sel = proc_ff[ccs_pkg::B_CPU_SEL];
   assign src_sel = mode_ff[ccs_pkg::B_SRC_SEL];
   assign mode_bit = mode_ff[ccs_pkg::B_MODE_BIT];
   assign ext_main = osc_ff[ccs_pkg::B_EXT_MAIN];

   // low-speed clock has no code here, so it can never reach the cpu
   always_comb begin
      main_src = ext_main ? ccs_pkg::SRC_EXT : ccs_pkg::SRC_X1;
      req_per = src_sel ? main_src : ccs_pkg::SRC_IHS;
      if (cpu_sel) begin
         req_cpu = ccs_pkg::SRC_SUB;
      end else if (src_sel && mode_bit) begin
         req_cpu = main_src;
      end else begin
         req_cpu = ccs_pkg::SRC_IHS;
      end
   end

   // -------------------------------------------------------------------------
   // switch completion
   // -------------------------------------------------------------------------
   // a change of the requested source waits the settling time before the
   // output and the status flags move; a new request mid-switch keeps the count, which clears when request matches output and at each commit
   logic [7:0] sw_cnt_ff;
   localparam logic [7:0] SW_LAST = 8'(SWITCH_CYCLES - 1);
   always_ff @(posedge clk_i) begin
      if (rst_i || req_cpu == cpu_clk_src_o) begin
         sw_cnt_ff <= 8'h00;
      end else if (sw_cnt_ff != SW_LAST) begin
         sw_cnt_ff <= sw_cnt_ff + 8'h01;
      end else begin
         sw_cnt_ff <= 8'h00;
      end
   end

   // cpu source commit; status flags derive from this flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_clk_src_o <= ccs_pkg::SRC_IHS;
      end else if (req_cpu != cpu_clk_src_o && sw_cnt_ff == SW_LAST) begin
         cpu_clk_src_o <= req_cpu;
      end
   end

   // peripheral source follows the registers directly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_clk_src_o <= ccs_pkg::SRC_IHS;
      end else begin
         per_clk_src_o <= req_per;
      end
   end

   // -------------------------------------------------------------------------
   // oscillator enables
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_en_o <= '0;
         osc_en_o.ihs_en <= 1'b1;
         osc_en_o.ls_en <= 1'b1;
      end else begin
         osc_en_o.ihs_en <= ~stop_mode_i;
         // main side runs only with stop bit zero
         osc_en_o.x1_en <= osc_ff[ccs_pkg::B_MAIN_OSC] & ~ext_main & ~mainc_ff[ccs_pkg::B_MAIN_STOP];
         osc_en_o.ext_en <= osc_ff[ccs_pkg::B_MAIN_OSC] & ext_main & ~mainc_ff[ccs_pkg::B_MAIN_STOP];
         osc_en_o.amp_hi <= osc_ff[ccs_pkg::B_GAIN];
         // subsystem side ignores stop mode: the select bit gates both, the external-input bit picks one
         osc_en_o.xt1_en <= osc_ff[ccs_pkg::B_SUB_SEL] & ~osc_ff[ccs_pkg::B_EXT_SUB];
         osc_en_o.exts_en <= osc_ff[ccs_pkg::B_SUB_SEL] & osc_ff[ccs_pkg::B_EXT_SUB];
         // stop bit honoured only when the option allows it
         osc_en_o.ls_en <= ~(iosc_ff[ccs_pkg::B_LSSTOP] & ls_stoppable);
      end
   end

   // -------------------------------------------------------------------------
   // wishbone answer
   // -------------------------------------------------------------------------
   logic sub_st, main_st; // status flags from the committed source
   logic [7:0] rd_byte;
   assign sub_st = (cpu_clk_src_o == ccs_pkg::SRC_SUB);
   assign main_st = (cpu_clk_src_o == ccs_pkg::SRC_X1) || (cpu_clk_src_o == ccs_pkg::SRC_EXT);

   // read mux; unmapped addresses read zero
   always_comb begin
      case (wb_adr_i)
         ccs_pkg::ADR_PROC: begin
            rd_byte = proc_ff | (8'(sub_st) << ccs_pkg::B_SUB_ST);
         end
         ccs_pkg::ADR_MODE: begin
            rd_byte = mode_ff | (8'(main_st) << ccs_pkg::B_MAIN_ST);
         end
         ccs_pkg::ADR_OSC: begin
            rd_byte = osc_ff;
         end
         ccs_pkg::ADR_IOSC: begin
            rd_byte = iosc_ff;
         end
         ccs_pkg::ADR_MAIN: begin
            rd_byte = mainc_ff;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // one-cycle ack, data registered with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
         end
      end
   end
endmodule

// ===== ccs_clock_ctrl_props.sv
// checker for the clock source control: bus answer, steering and status flags
// assumes it is bound to ccs_clock_ctrl and that all logic runs on clk_i
`timescale 1ns/1ps
module ccs_clock_ctrl_props #(
   parameter int SWITCH_CYCLES = 3 // source switch settling
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ls_stoppable_opt_i,
   input wire logic stop_mode_i,
   input wire ccs_pkg::ccs_src_e cpu_clk_src_o,
   input wire ccs_pkg::ccs_src_e per_clk_src_o,
   input wire ccs_pkg::ccs_osc_s osc_en_o
);
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   logic [7:0] since_chg_ff; // cycles since the cpu source last moved

   // saturating, so a long quiet stretch never wraps to a false small gap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_chg_ff <= 8'h00;
      end else if ($changed(cpu_clk_src_o)) begin
         since_chg_ff <= 8'h00;
      end else if (since_chg_ff != 8'hFF) begin
         since_chg_ff <= since_chg_ff + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   reset_start_a: assert property (disable iff (1'b0) rst_i |=>
      cpu_clk_src_o == ccs_pkg::SRC_IHS && osc_en_o.ihs_en && osc_en_o.ls_en)
      else $error("reset state not on internal clock with low-speed running");
   per_never_sub_a: assert property (per_clk_src_o != ccs_pkg::SRC_SUB)
      else $error("peripherals fed from subsystem clock");
   ls_lock_on_a: assert property (!ls_stoppable_opt_i [*5] |-> osc_en_o.ls_en)
      else $error("low-speed oscillator stopped while locked on");
   stop_keeps_sub_a: assert property (
      stop_mode_i && !wb_cyc_i && !$past(wb_cyc_i) |=>
      $stable(osc_en_o.xt1_en) && $stable(osc_en_o.exts_en))
      else $error("stop state disturbed the subsystem clock");
   sub_status_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ccs_pkg::ADR_PROC && $stable(cpu_clk_src_o) |->
      wb_dat_o[ccs_pkg::B_SUB_ST] == (cpu_clk_src_o == ccs_pkg::SRC_SUB))
      else $error("subsystem status flag disagrees with cpu source");
   main_status_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == ccs_pkg::ADR_MODE && $stable(cpu_clk_src_o) |->
      wb_dat_o[ccs_pkg::B_MAIN_ST] == (cpu_clk_src_o inside {ccs_pkg::SRC_X1, ccs_pkg::SRC_EXT}))
      else $error("main status flag disagrees with cpu source");
   switch_gap_a: assert property ($changed(cpu_clk_src_o) |->
      since_chg_ff >= SWITCH_CYCLES - 1)
      else $error("cpu source moved without settling");
endmodule

bind ccs_clock_ctrl ccs_clock_ctrl_props #(.SWITCH_CYCLES(SWITCH_CYCLES)) ccs_clock_ctrl_props_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .ls_stoppable_opt_i, .stop_mode_i, .cpu_clk_src_o, .per_clk_src_o, .osc_en_o
);

// ===== tb.sv
// testbench for the clock source control: bus, steering table, oscillators
// assumes ccs_pkg, the design and its checker are compiled before it
`timescale 1ns/1ps
module tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int SW = 3; // shortened switch settling
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic ls_opt = 1'b1; // low-speed may be stopped
   logic stop = 1'b0; // stop standby state
   logic dual = 1'b0; // dual-threshold power-on option
   logic vdd = 1'b1; // supply above upper threshold
   logic [31:0] rdat;
   logic ack, run;
   ccs_pkg::ccs_src_e cpu_src, per_src;
   ccs_pkg::ccs_osc_s osc;
   int miscompares = 0;
   int tests_run = 0;

   always #2 clk_i = ~clk_i; // 250 MHz

   // dual option and supply are driven by the power-on scenario only
   ccs_clock_ctrl #(.RSTPROC_CYCLES(20), .SWITCH_CYCLES(SW)) ccs_clock_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ls_stoppable_opt_i(ls_opt), .dual_threshold_por_option_i(dual),
      .vdd_above_upper_i(vdd), .stop_mode_i(stop), .cpu_clk_src_o(cpu_src),
      .per_clk_src_o(per_src), .osc_en_o(osc), .cpu_run_o(run)
   );

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   // verdict and end of run, also reached from the watchdog
   task automatic stop_test();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // wait n edges, then look at settled outputs half a cycle later
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // one classic cycle, driven at a rising edge; ack is looked at settled,
   // so the edge after a high look is the one where the master sees it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(negedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (ack !== 1'b1) miscompares++; // no answer
      q = rdat;
      @(posedge clk_i);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // state straight out of reset, with no programming
   task automatic t_reset();
      settle(3);
      chk(run, 1'b1);
      chk(cpu_src, ccs_pkg::SRC_IHS);
      chk(per_src, ccs_pkg::SRC_IHS);
      chk(osc, 7'h41);
      rd(ccs_pkg::ADR_PROC, 32'h0);
      rd(ccs_pkg::ADR_MODE, 32'h0);
      rd(ccs_pkg::ADR_OSC, 32'h0);
      rd(ccs_pkg::ADR_IOSC, {24'h0, ccs_pkg::RST_IOSC});
      rd(ccs_pkg::ADR_MAIN, {24'h0, ccs_pkg::RST_MAIN});
      rd(8'h14, 32'h0); // unmapped place reads zero
   endtask

   // every select, mode and input combination, subsystem kept running
   task automatic t_table();
      logic x, c, m, k;
      logic [1:0] ep;
      wr(ccs_pkg::ADR_MAIN, 32'h0);
      for (int i = 0; i < 16; i++) begin
         {x, c, m, k} = i[3:0];
         ep = x ? {k, 1'b1} : 2'h0;
         wr(ccs_pkg::ADR_OSC, {24'h0, k, 3'b101, 3'b000, m});
         wr(ccs_pkg::ADR_MODE, {29'h0, x, 1'b0, m});
         wr(ccs_pkg::ADR_PROC, {27'h0, c, 4'h0});
         settle(2 * SW + 4);
         chk(per_src, ep);
         chk(cpu_src, c ? 2'h2 : (x && m) ? ep : 2'h0);
         chk(osc[5:3], {~k, k, m});
         rd(ccs_pkg::ADR_PROC, {26'h0, c, c, 4'h0});
         rd(ccs_pkg::ADR_MODE, {29'h0, x, ~c & x & m, m});
      end
   endtask

   // flags lag until the switch is done, and the switch takes its settling time
   task automatic t_switch();
      int n;
      n = 0;
      wr(ccs_pkg::ADR_PROC, 32'h0);
      rd(ccs_pkg::ADR_PROC, 32'h20);
      settle(2 * SW + 4);
      chk(cpu_src, ccs_pkg::SRC_EXT);
      wr(ccs_pkg::ADR_PROC, 32'h10);
      while (cpu_src !== ccs_pkg::SRC_SUB && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      chk(n >= SW && n <= SW + 1, 1'b1);
   endtask

   // leave the subsystem clock, then crystal, external input and stop
   task automatic t_subsys();
      wr(ccs_pkg::ADR_PROC, 32'h0);
      settle(2 * SW + 4);
      rd(ccs_pkg::ADR_PROC, 32'h0);
      wr(ccs_pkg::ADR_OSC, 32'h50);
      stop <= 1'b1;
      settle(4);
      chk({osc.ihs_en, osc.xt1_en, osc.exts_en}, 3'b010);
      @(posedge clk_i);
      stop <= 1'b0;
      wr(ccs_pkg::ADR_OSC, 32'h70);
      settle(2);
      chk({osc.ihs_en, osc.xt1_en, osc.exts_en}, 3'b101);
      wr(ccs_pkg::ADR_OSC, 32'h40);
      settle(2);
      chk({osc.xt1_en, osc.exts_en}, 2'b00);
   endtask

   // low-speed oscillator stop and restart, then the locked-on option
   task automatic t_lowspeed();
      wr(ccs_pkg::ADR_IOSC, 32'h02);
      settle(2);
      chk(osc.ls_en, 1'b0);
      chk(cpu_src, ccs_pkg::SRC_X1);
      wr(ccs_pkg::ADR_IOSC, 32'h00);
      settle(2);
      chk(osc.ls_en, 1'b1);
      @(posedge clk_i);
      ls_opt <= 1'b0;
      repeat (4) @(posedge clk_i);
      wr(ccs_pkg::ADR_IOSC, 32'h02);
      settle(2);
      chk(osc.ls_en, 1'b1);
      rd(ccs_pkg::ADR_IOSC, 32'h02);
      ls_opt <= 1'b1;
   endtask

   // second reset in dual-threshold mode: cpu waits for supply, then interval
   task automatic t_por();
      int n;
      n = 0;
      @(posedge clk_i);
      rst_i <= 1'b1;
      dual <= 1'b1;
      vdd <= 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      settle(8);
      chk(run, 1'b0);
      chk(cpu_src, ccs_pkg::SRC_IHS);
      rd(ccs_pkg::ADR_PROC, 32'h0);
      @(posedge clk_i);
      vdd <= 1'b1;
      while (run !== 1'b1 && n < 60) begin
         @(negedge clk_i);
         n++;
      end
      chk(n >= 20 && n <= 26, 1'b1);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_table();
      t_switch();
      t_subsys();
      t_lowspeed();
      t_por();
      stop_test();
   end

   // the whole run needs well under 2000 cycles
   initial begin
      #(4 * 5000);
      miscompares++;
      stop_test();
   end
endmodule
